// File: boundary_scan_tap_instructions_bench.sv
// self-checking bench for the boundary-scan instruction block
// assumes bstap_ctl on the scan side; mclk 100 ns, tck 15 ns within frames
`include "bstap_cfg.svh"

module boundary_scan_tap_instructions_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rstn, scan_tck, scan_tdi, scan_tdo, scan_tdo_oe, extest_active;
    logic tap_test_reset, tap_capture_ir, tap_shift_ir, tap_update_ir;
    logic tap_capture_dr, tap_shift_dr, tap_update_dr;
    logic [`BSTAP_PIN_W-1:0] pin_in, core_in, core_out, pin_out;
    logic [3:0] instr_code, cap;
    logic [16:0] d, o, e;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    bstap_instr DUT (.*);
    bstap_ctl ctl (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    initial begin
        void'($urandom(32'h566cf34a));
        rstn = 1'b0;
        pin_in = 8'h00;
        core_out = 8'h00;
        repeat (4) ctl.step(7'h40, 1'b1, o[0]);
        repeat (12) @(negedge mclk);
        check(17'(instr_code), 17'h00009);
        check(17'(pin_out), 17'h00000);
        rstn = 1'b1;
        for (int c = 0; c < 16; c++) begin
            @(negedge mclk);
            core_out = 8'($urandom);
            pin_in = 8'($urandom);
            repeat (3) @(negedge mclk);
            ctl.ir_scan(4'(c), cap);
            check(17'(cap), 17'h00009);
            check(17'(instr_code), 17'(c));
            d = 17'($urandom);
            ctl.dr_scan(d, o);
            // model: boundary path returns captured cells, bypass delays tdi one stage
            e = (c == 0 || c == 4) ? {d[0], pin_in, core_out} : {d[15:0], 1'b0};
            check(o, e);
            repeat (8) @(negedge mclk);
            check(17'(extest_active), 17'(c == 0));
            check(17'(pin_out), 17'(c == 0 ? d[8:1] : core_out));
            check(17'(core_in), 17'(pin_in));
        end
        results();
    end
endmodule : boundary_scan_tap_instructions_bench

// File: bstap_cfg.svh
// boundary-scan instruction handling constants
// assumes inclusion by bstap_pkg, the instruction block, its port checks and the bench
`ifndef BSTAP_CFG_SVH
`define BSTAP_CFG_SVH

// instruction register width
`define BSTAP_IR_W 4

// capture-ir default pattern and reset value of the instruction latch
`define BSTAP_IR_CAPTURE 4'h9
`define BSTAP_IR_RESET 4'h9

// instruction codes
`define BSTAP_CODE_EXTEST 4'h0
`define BSTAP_CODE_SAMPLE 4'h4

// instruction bit positions of the serial ends
`define BSTAP_IR_MSB 3
`define BSTAP_IR_LSB 0

// boundary-scan cells: one input cell and one output cell per pin
`define BSTAP_PIN_W 8

// bypass stage capture value
`define BSTAP_BYPASS_CAPTURE 1'b0

`endif

// File: bstap_ctl.sv
// board-side scan controller model: tck runs only within frames
// assumes the one-hot tap levels of bstap_instr; tdi idles high as if pulled up
module bstap_ctl (
    output logic scan_tck,
    output logic scan_tdi,
    input wire logic scan_tdo,
    output logic tap_test_reset,
    output logic tap_capture_ir,
    output logic tap_shift_ir,
    output logic tap_update_ir,
    output logic tap_capture_dr,
    output logic tap_shift_dr,
    output logic tap_update_dr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [6:0] st_reg;

    assign {tap_test_reset, tap_capture_ir, tap_shift_ir, tap_update_ir, tap_capture_dr,
        tap_shift_dr, tap_update_dr} = st_reg;

    initial begin
        scan_tck = 1'b0;
        scan_tdi = 1'b1;
        st_reg = 7'h40;
    end

    // levels move 1 ns after the falling edge, clear of both tck edges
    task automatic step(input logic [6:0] st, input logic d, output logic q);
        #1;
        st_reg = st;
        scan_tdi = d;
        q = scan_tdo;
        #6.5 scan_tck = 1'b1;
        #7.5 scan_tck = 1'b0;
    endtask : step

    task automatic ir_scan(input logic [3:0] code, output logic [3:0] cap);
        logic q;
        step(7'h00, 1'b1, q);
        step(7'h20, 1'b1, q);
        for (int i = 0; i < 4; i++) step(7'h10, code[i], cap[i]);
        step(7'h00, 1'b1, q);
        step(7'h08, 1'b1, q);
        step(7'h00, 1'b1, q);
    endtask : ir_scan

    // idle periods first so the tck-side pin synchronisers settle
    task automatic dr_scan(input logic [16:0] d, output logic [16:0] o);
        logic q;
        repeat (3) step(7'h00, 1'b1, q);
        step(7'h04, 1'b1, q);
        for (int i = 0; i < 17; i++) step(7'h02, d[i], o[i]);
        step(7'h00, 1'b1, q);
        step(7'h01, 1'b1, q);
        step(7'h00, 1'b1, q);
    endtask : dr_scan
endmodule : bstap_ctl

// File: bstap_instr.sv
// boundary-scan instruction register, decode, bypass stage and boundary cells
// assumes an external tap state machine on scan_tck giving one-hot state levels,
// and core logic on mclk that owns the normal pin values
`include "bstap_cfg.svh"

// Overview of operation
// - four-bit shift stage plus parallel instruction latch
// - tdi enters msb, lsb drives tdo
// - capture-ir loads pattern 1001 (bypass)
// - shift-ir advances one bit per rising tck
// - code 0000 is extest, boundary chain in path
// - code 0100 is sample/preload, pins undisturbed
// - every other code decodes as bypass
// - bypass path is exactly one stage
// - all-ones scan leaves bypass selected
// - sample captures input pins on rising tck
// - preload latches output cells on falling tck
// - extest capture matches sample capture
// - extest update latches and drives output pins
module bstap_instr (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scan_tck,
    input wire logic scan_tdi,
    output logic scan_tdo,
    output logic scan_tdo_oe,
    input wire logic tap_test_reset,
    input wire logic tap_capture_ir,
    input wire logic tap_shift_ir,
    input wire logic tap_update_ir,
    input wire logic tap_capture_dr,
    input wire logic tap_shift_dr,
    input wire logic tap_update_dr,
    input wire logic [`BSTAP_PIN_W-1:0] pin_in,
    output logic [`BSTAP_PIN_W-1:0] core_in,
    input wire logic [`BSTAP_PIN_W-1:0] core_out,
    output logic [`BSTAP_PIN_W-1:0] pin_out,
    output logic [`BSTAP_IR_W-1:0] instr_code,
    output logic extest_active
);

    // instruction decode; anything but the two scan codes is bypass
    function automatic bstap_pkg::bstap_op_t decode_op(
        input logic [`BSTAP_IR_W-1:0] code
    );
        bstap_pkg::bstap_op_t op;
        op = bstap_pkg::BSTAP_OP_BYPASS;
        if (code == `BSTAP_CODE_EXTEST) begin
            op = bstap_pkg::BSTAP_OP_EXTEST;
        end else if (code == `BSTAP_CODE_SAMPLE) begin
            op = bstap_pkg::BSTAP_OP_SAMPLE;
        end
        return op;
    endfunction : decode_op

    // ---------------- scan clock domain ----------------

    logic [`BSTAP_IR_W-1:0] instruction_shift_reg;
    logic [`BSTAP_IR_W-1:0] instruction_shift_next;
    logic [`BSTAP_IR_W-1:0] instruction_shift_latch_reg;
    logic bypass_reg;
    logic bypass_next;
    bstap_pkg::bstap_pins_t bsr_in_reg;
    bstap_pkg::bstap_pins_t bsr_in_next;
    bstap_pkg::bstap_pins_t bsr_out_reg;
    bstap_pkg::bstap_pins_t bsr_out_next;
    bstap_pkg::bstap_pins_t bsr_update_reg;
    bstap_pkg::bstap_pins_t pin_meta_reg;
    bstap_pkg::bstap_pins_t pin_sync_reg;
    bstap_pkg::bstap_pins_t core_meta_reg;
    bstap_pkg::bstap_pins_t core_sync_reg;
    logic update_toggle_reg;
    logic tdo_reg;
    logic tdo_oe_reg;

    wire bstap_pkg::bstap_op_t cur_op = decode_op(instruction_shift_latch_reg);
    wire op_is_bypass = (cur_op == bstap_pkg::BSTAP_OP_BYPASS);
    wire op_is_extest = (cur_op == bstap_pkg::BSTAP_OP_EXTEST);
    wire op_uses_bsr = !op_is_bypass;

    // boundary chain: tdi -> input cells -> output cells -> tdo
    wire [2*`BSTAP_PIN_W-1:0] bsr_chain = {bsr_in_reg, bsr_out_reg};
    wire [2*`BSTAP_PIN_W-1:0] bsr_shifted = {scan_tdi, bsr_chain[2*`BSTAP_PIN_W-1:1]};

    // instruction shift stage next value
    always_comb begin
        instruction_shift_next = instruction_shift_reg;
        if (tap_capture_ir) begin
            instruction_shift_next = `BSTAP_IR_CAPTURE;
        end else if (tap_shift_ir) begin
            // new bit at msb, lsb falls off toward tdo
            instruction_shift_next = {scan_tdi,
                instruction_shift_reg[`BSTAP_IR_MSB:`BSTAP_IR_LSB+1]};
        end
    end

    // bypass stage: a single flop in the path
    always_comb begin
        bypass_next = bypass_reg;
        if (tap_capture_dr && op_is_bypass) begin
            bypass_next = `BSTAP_BYPASS_CAPTURE;
        end else if (tap_shift_dr && op_is_bypass) begin
            bypass_next = scan_tdi;
        end
    end

    // boundary cells: capture pins, shift chain
    always_comb begin
        bsr_in_next = bsr_in_reg;
        bsr_out_next = bsr_out_reg;
        if (tap_capture_dr && op_uses_bsr) begin
            // same capture for sample and extest
            bsr_in_next = pin_sync_reg;
            bsr_out_next = core_sync_reg;
        end else if (tap_shift_dr && op_uses_bsr) begin
            bsr_in_next = bsr_shifted[2*`BSTAP_PIN_W-1:`BSTAP_PIN_W];
            bsr_out_next = bsr_shifted[`BSTAP_PIN_W-1:0];
        end
    end

    // serial data selected by state and instruction
    // the ir path owns tdo from capture-ir on, so the captured lsb leaves first
    wire ir_path = tap_capture_ir || tap_shift_ir;
    wire scan_serial_bit = ir_path ? instruction_shift_reg[`BSTAP_IR_LSB] :
        (op_is_bypass ? bypass_reg : bsr_chain[0]);
    wire scan_shifting = tap_shift_ir || tap_shift_dr;

    // pin inputs and core outputs reach the capture cells through two flops
    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            pin_meta_reg <= '0;
        end else begin
            pin_meta_reg <= pin_in;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            pin_sync_reg <= '0;
        end else begin
            pin_sync_reg <= pin_meta_reg;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            core_meta_reg <= '0;
        end else begin
            core_meta_reg <= core_out;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            core_sync_reg <= '0;
        end else begin
            core_sync_reg <= core_meta_reg;
        end
    end

    // rising-edge shift and capture stages
    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            instruction_shift_reg <= `BSTAP_IR_RESET;
        end else begin
            instruction_shift_reg <= instruction_shift_next;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            bypass_reg <= 1'b0;
        end else begin
            bypass_reg <= bypass_next;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            bsr_in_reg <= '0;
        end else begin
            bsr_in_reg <= bsr_in_next;
        end
    end

    always_ff @(posedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            bsr_out_reg <= '0;
        end else begin
            bsr_out_reg <= bsr_out_next;
        end
    end

    // falling-edge instruction latch; only update-ir or test reset move it
    always_ff @(negedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            instruction_shift_latch_reg <= `BSTAP_IR_RESET;
        end else if (tap_test_reset) begin
            instruction_shift_latch_reg <= `BSTAP_IR_RESET;
        end else if (tap_update_ir) begin
            instruction_shift_latch_reg <= instruction_shift_reg;
        end
    end

    // falling-edge update latch of the output cells, for preload and extest
    always_ff @(negedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            bsr_update_reg <= '0;
            update_toggle_reg <= 1'b0;
        end else if (tap_update_dr && op_uses_bsr) begin
            bsr_update_reg <= bsr_out_reg;
            update_toggle_reg <= !update_toggle_reg;
        end
    end

    // tdo changes on the falling edge, driven only while shifting
    always_ff @(negedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            tdo_reg <= 1'b0;
        end else begin
            tdo_reg <= scan_serial_bit;
        end
    end

    always_ff @(negedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            tdo_oe_reg <= 1'b0;
        end else begin
            tdo_oe_reg <= scan_shifting;
        end
    end

    // extest level leaves the scan domain as a registered flag
    logic extest_scan_reg;
    always_ff @(negedge scan_tck or negedge rstn) begin
        if (!rstn) begin
            extest_scan_reg <= 1'b0;
        end else begin
            extest_scan_reg <= op_is_extest;
        end
    end

    assign scan_tdo = tdo_reg;
    assign scan_tdo_oe = tdo_oe_reg;
    assign instr_code = instruction_shift_latch_reg;

    // ---------------- system clock domain ----------------

    logic extest_meta_reg;
    logic extest_sync_reg;
    logic toggle_meta_reg;
    logic toggle_sync_reg;
    logic toggle_seen_reg;
    bstap_pkg::bstap_pins_t drive_word_reg;
    bstap_pkg::bstap_pins_t drive_word_next;
    bstap_pkg::bstap_pins_t pin_out_reg;
    bstap_pkg::bstap_pins_t pin_out_next;
    bstap_pkg::bstap_pins_t core_in_meta_reg;
    bstap_pkg::bstap_pins_t core_in_reg;

    // a new update word is announced by a toggle; the word is stable by then
    wire update_event = toggle_sync_reg ^ toggle_seen_reg;

    always_comb begin
        drive_word_next = drive_word_reg;
        if (update_event) begin
            drive_word_next = bsr_update_reg;
        end
    end

    // sample/preload leaves the pins to the core; extest drives them
    always_comb begin
        pin_out_next = core_out;
        if (extest_sync_reg) begin
            pin_out_next = drive_word_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            extest_meta_reg <= 1'b0;
        end else begin
            extest_meta_reg <= extest_scan_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            extest_sync_reg <= 1'b0;
        end else begin
            extest_sync_reg <= extest_meta_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            toggle_meta_reg <= 1'b0;
        end else begin
            toggle_meta_reg <= update_toggle_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            toggle_sync_reg <= 1'b0;
        end else begin
            toggle_sync_reg <= toggle_meta_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            toggle_seen_reg <= 1'b0;
        end else begin
            toggle_seen_reg <= toggle_sync_reg;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            drive_word_reg <= '0;
            pin_out_reg <= '0;
        end else begin
            drive_word_reg <= drive_word_next;
            pin_out_reg <= pin_out_next;
        end
    end

    // input pins pass to the core through two flops, undisturbed by scan
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            core_in_meta_reg <= '0;
            core_in_reg <= '0;
        end else begin
            core_in_meta_reg <= pin_in;
            core_in_reg <= core_in_meta_reg;
        end
    end

    assign pin_out = pin_out_reg;
    assign core_in = core_in_reg;
    assign extest_active = extest_sync_reg;

endmodule : bstap_instr

// File: bstap_instr_sva.sv
// port checks for the boundary-scan instruction block
// assumes tap levels move between tck edges; bound by port name
`include "bstap_cfg.svh"

module bstap_instr_sva (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic scan_tck,
    input wire logic scan_tdi,
    input wire logic scan_tdo,
    input wire logic scan_tdo_oe,
    input wire logic tap_test_reset,
    input wire logic tap_capture_ir,
    input wire logic tap_shift_ir,
    input wire logic tap_update_ir,
    input wire logic tap_shift_dr,
    input wire logic tap_update_dr,
    input wire logic [`BSTAP_PIN_W-1:0] core_out,
    input wire logic [`BSTAP_PIN_W-1:0] pin_out,
    input wire logic [`BSTAP_IR_W-1:0] instr_code,
    input wire logic extest_active
);
    a_ir_capture: assert property (@(negedge scan_tck) disable iff (!rstn)
        tap_capture_ir ##1 tap_shift_ir [*4] |-> scan_tdo && !$past(scan_tdo)
        && !$past(scan_tdo, 2) && $past(scan_tdo, 3)) else $error("ir capture");
    a_latch_update: assert property (@(negedge scan_tck) disable iff (!rstn)
        $changed(instr_code) |-> $past(tap_update_ir) || $past(tap_test_reset))
        else $error("ir latch moved");
    a_bypass_stage: assert property (@(posedge scan_tck) disable iff (!rstn)
        tap_shift_dr && instr_code != 4'h0 && instr_code != 4'h4 |=>
        scan_tdo == $past(scan_tdi)) else $error("bypass length");
    a_extest_set: assert property (@(posedge mclk) disable iff (!rstn)
        (instr_code == 4'h0) [*4] |-> extest_active) else $error("extest missed");
    a_extest_clear: assert property (@(posedge mclk) disable iff (!rstn)
        (instr_code != 4'h0) [*4] |-> !extest_active) else $error("extest wrong");
    a_pins_follow: assert property (@(posedge mclk) disable iff (!rstn)
        !extest_active [*2] |=> pin_out == $past(core_out)) else $error("pins left core");
    a_oe_idle: assert property (@(negedge scan_tck) disable iff (!rstn)
        !(tap_shift_ir || tap_shift_dr) [*3] |-> !scan_tdo_oe) else $error("tdo oe idle");
    a_oe_shift: assert property (@(negedge scan_tck) disable iff (!rstn)
        (tap_shift_ir || tap_shift_dr) [*3] |-> scan_tdo_oe) else $error("tdo oe shift");
    c_extest: cover property (@(posedge mclk) $rose(extest_active));
    c_bypass: cover property (@(posedge scan_tck) tap_shift_dr && instr_code == 4'h9);
    c_preload: cover property (@(posedge scan_tck) tap_update_dr && instr_code == 4'h4);
endmodule : bstap_instr_sva

bind bstap_instr bstap_instr_sva u_sva (.*);

// File: bstap_pkg.sv
// types shared by the boundary-scan instruction block
// assumes bstap_cfg.svh is on the include path
`include "bstap_cfg.svh"

package bstap_pkg;

    // decoded instruction, one code per supported operation
    typedef enum logic [1:0] {
        BSTAP_OP_EXTEST = 2'b00,
        BSTAP_OP_SAMPLE = 2'b01,
        BSTAP_OP_BYPASS = 2'b10
    } bstap_op_t;

    typedef logic [`BSTAP_IR_W-1:0] bstap_ir_t;

    typedef logic [`BSTAP_PIN_W-1:0] bstap_pins_t;

endpackage : bstap_pkg
